// >>> src/eprom_access_map.svh
// Constants for the EPROM access port
`ifndef EPROM_ACCESS_MAP_SVH
`define EPROM_ACCESS_MAP_SVH
`define EPA_ADDR_W 13
`define EPA_DATA_W 8
`define EPA_DEPTH 8192
`define EPA_ERASED 8'hFF
`define EPA_HI_ADDR_BITS 5
`define EPA_CE_BIT 2
`define EPA_OE_BIT 1
`define EPA_PGM_BIT 0
`endif

// >>> src/eprom_access_pkg.sv
// Types for the EPROM access port
`default_nettype none
package eprom_access_pkg;
  typedef logic [12:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_READ = 2'b01,
    MODE_PROG = 2'b10,
    MODE_DISABLE = 2'b11
  } mode_t;
endpackage
`default_nettype wire

// >>> src/eprom_mem_if.sv
// Interface between access control and storage array
`timescale 1ns/1ns
`default_nettype none
interface eprom_mem_if;
  eprom_access_pkg::addr_t addr;
  eprom_access_pkg::byte_t wrData;
  logic wrEn;
  eprom_access_pkg::byte_t rdData;
  modport ctrl (output addr, output wrData, output wrEn, input rdData);
  modport mem (input addr, input wrData, input wrEn, output rdData);
endinterface
`default_nettype wire

// >>> src/eprom_array.sv
// Flip-flop storage array for the on-chip EPROM
`timescale 1ns/1ns
`default_nettype none
`include "eprom_access_map.svh"
module eprom_array
(
  input wire logic clk,
  eprom_mem_if.mem bus
);
  eprom_access_pkg::byte_t cells [`EPA_DEPTH] = '{default: `EPA_ERASED};

  // Programming only clears bits, like a real EPROM cell
  genvar i;
  generate
    for (i = 0; i < `EPA_DEPTH; i++)
    begin : g_cell
      always_ff @(posedge clk)
      begin
        if (bus.wrEn && bus.addr == 13'(i))
        begin
          cells[i] <= cells[i] & bus.wrData;
        end
      end
    end
  endgenerate

  assign bus.rdData = cells[bus.addr];
endmodule
`default_nettype wire

// >>> src/eprom_mode_access_port.sv
// EPROM access mode port logic of the single-chip controller
//
// Notes on behaviour
// - Reset held low selects EPROM access mode on the dedicated ports
// - Address bits seven to zero come from port_a
// - Address bits twelve to eight from port_b low five; top three held high
// - port_c is the bidirectional eight-bit memory data bus
// - port_e bits two, one, zero are chip, output enable, program strobe
// - Chip and output enable low, strobe high: stored byte driven out
// - Data bus floats whenever chip or output enable is high
// - Programming accepted only while programming voltage is present
// - Byte is programmed on a falling edge of the program strobe
// - Verify with voltage applied reads back the stored byte
`timescale 1ns/1ns
`default_nettype none
`include "eprom_access_map.svh"
module eprom_mode_access_port
(
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_n,
  input wire logic mode_supply_pin,
  input wire logic [7:0] port_a,
  input wire logic [7:0] port_b,
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic port_c_oe,
  input wire logic [7:0] port_e,
  output logic access_mode,
  output logic prog_busy
);
  eprom_mem_if memBus ();

  logic accessMode_q;
  logic chipEn;
  logic outEn;
  logic strobe;
  logic strobe_q;
  logic strobeFall;
  logic [7:0] dataOut_q;
  logic dataOe_q;
  logic progBusy_q;
  logic lastValid_q;
  eprom_access_pkg::addr_t lastAddr_q;
  eprom_access_pkg::byte_t lastData_q;
  eprom_access_pkg::mode_t mode;

  eprom_array u_array
  (
    .clk (clk),
    .bus (memBus)
  );

  // Mode entry follows the reset pin
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      accessMode_q <= 1'b0;
    end
    else
    begin
      accessMode_q <= !reset_n;
    end
  end

  assign chipEn = !port_e[`EPA_CE_BIT] && accessMode_q;
  assign outEn = !port_e[`EPA_OE_BIT];
  assign strobe = port_e[`EPA_PGM_BIT];

  // Address assembly; port_b top bits and port_e straps are the programmer's
  assign memBus.addr = {port_b[`EPA_HI_ADDR_BITS-1:0], port_a};
  assign memBus.wrData = port_c_in;

  always_comb
  begin
    if (!chipEn)
    begin
      mode = eprom_access_pkg::MODE_DISABLE;
    end
    else if (outEn && strobe)
    begin
      mode = eprom_access_pkg::MODE_READ;
    end
    else if (!outEn && mode_supply_pin)
    begin
      mode = eprom_access_pkg::MODE_PROG;
    end
    else
    begin
      mode = eprom_access_pkg::MODE_IDLE;
    end
  end

  // Strobe edge tracking
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      strobe_q <= 1'b1;
    end
    else
    begin
      strobe_q <= strobe;
    end
  end

  assign strobeFall = strobe_q && !strobe;
  assign memBus.wrEn = strobeFall && (mode == eprom_access_pkg::MODE_PROG);

  // Program activity flag, held while the strobe stays low and mode stays MODE_PROG
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      progBusy_q <= 1'b0;
    end
    else if (memBus.wrEn)
    begin
      progBusy_q <= 1'b1;
    end
    else if (strobe || mode != eprom_access_pkg::MODE_PROG)
    begin
      progBusy_q <= 1'b0;
    end
  end

  // Data bus enable, only while reading
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dataOe_q <= 1'b0;
    end
    else
    begin
      dataOe_q <= (mode == eprom_access_pkg::MODE_READ);
    end
  end

  // Data bus value, zero while floating
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dataOut_q <= 8'h00;
    end
    else
    begin
      unique case (mode)
        eprom_access_pkg::MODE_READ:
        begin
          dataOut_q <= memBus.rdData;
        end
        eprom_access_pkg::MODE_PROG,
        eprom_access_pkg::MODE_IDLE,
        eprom_access_pkg::MODE_DISABLE:
        begin
          dataOut_q <= 8'h00;
        end
      endcase
    end
  end

  // Last programmed location, for the verify check
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      lastValid_q <= 1'b0;
      lastAddr_q <= 13'h0000;
      lastData_q <= 8'hFF;
    end
    else if (memBus.wrEn)
    begin
      lastValid_q <= 1'b1;
      lastAddr_q <= memBus.addr;
      lastData_q <= memBus.wrData;
    end
  end

  assign port_c_out = dataOut_q;
  assign port_c_oe = dataOe_q;
  assign access_mode = accessMode_q;
  assign prog_busy = progBusy_q;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Mode entry
  mode_follow_a: assert property (##1 access_mode == !$past(reset_n))
    else $error("access mode does not follow reset pin");

  mode_leave_a: assert property (reset_n |=> !access_mode)
    else $error("access mode kept with reset pin high");

  mode_only_a: assert property (!access_mode |-> !memBus.wrEn)
    else $error("write outside access mode");

  mode_float_a: assert property (!access_mode |=> !port_c_oe)
    else $error("bus driven outside access mode");

  mode_busy_a: assert property (!access_mode |=> !prog_busy)
    else $error("busy outside access mode");

  // Bus drive and float
  float_ce_a: assert property (port_e[`EPA_CE_BIT] |=> !port_c_oe)
    else $error("bus driven with chip enable high");

  float_oe_a: assert property (port_e[`EPA_OE_BIT] |=> !port_c_oe)
    else $error("bus driven with output enable high");

  float_read_a: assert property (!(access_mode && port_e[2:0] == 3'h1)
    |=> !port_c_oe)
    else $error("bus driven outside a read");

  float_strobe_a: assert property (!port_e[`EPA_PGM_BIT] |=> !port_c_oe)
    else $error("bus driven with strobe low");

  idle_float_a: assert property ((access_mode && port_e[2:0] == 3'h3
    && !mode_supply_pin) |=> !port_c_oe)
    else $error("bus driven while idle");

  out_zero_a: assert property (!port_c_oe |-> port_c_out == 8'h00)
    else $error("data not cleared while floating");

  read_data_a: assert property ((access_mode && port_e[2:0] == 3'h1) |=>
    (port_c_oe && port_c_out == $past(memBus.rdData)))
    else $error("read did not drive stored byte");

  read_hold_a: assert property ((access_mode && port_e[2:0] == 3'h1)[*2]
    |-> port_c_oe)
    else $error("held read not driven");

  // Programming
  no_vpp_a: assert property (!mode_supply_pin |-> !memBus.wrEn)
    else $error("write without programming voltage");

  no_vpp_busy_a: assert property (!mode_supply_pin |=> !prog_busy)
    else $error("busy without programming voltage");

  busy_vpp_a: assert property (prog_busy |->
    ($past(mode_supply_pin) && $past(access_mode)))
    else $error("busy without programming state");

  write_edge_a: assert property (memBus.wrEn |-> $fell(port_e[`EPA_PGM_BIT]))
    else $error("write without strobe fall");

  write_go_a: assert property ((access_mode && port_e[2:1] == 2'b01
    && mode_supply_pin && $fell(port_e[`EPA_PGM_BIT])) |-> memBus.wrEn)
    else $error("program edge not taken");

  write_once_a: assert property (memBus.wrEn |=> !memBus.wrEn)
    else $error("second write without strobe rise");

  strobe_high_a: assert property (port_e[`EPA_PGM_BIT] |-> !memBus.wrEn)
    else $error("write with strobe high");

  oe_no_write_a: assert property (!port_e[`EPA_OE_BIT] |-> !memBus.wrEn)
    else $error("write with output enable low");

  busy_a: assert property (memBus.wrEn |=> prog_busy)
    else $error("busy not raised");

  busy_src_a: assert property ($rose(prog_busy) |-> $past(memBus.wrEn))
    else $error("busy without program edge");

  busy_drop_a: assert property ((prog_busy && port_e[`EPA_PGM_BIT]) |=> !prog_busy)
    else $error("busy kept after strobe rise");

  busy_hold_a: assert property ((prog_busy && access_mode && mode_supply_pin
    && port_e[2:0] == 3'h2) |=> prog_busy)
    else $error("busy dropped while strobe low");

  oe_busy_a: assert property (!port_e[`EPA_OE_BIT] |=> !prog_busy)
    else $error("busy with output enable low");

  ce_ignore_a: assert property (port_e[`EPA_CE_BIT] |-> !memBus.wrEn)
    else $error("write with chip enable high");

  ce_busy_a: assert property (port_e[`EPA_CE_BIT] |=> !prog_busy)
    else $error("busy with chip enable high");

  // Verify
  verify_a: assert property ((access_mode && mode_supply_pin && port_e[2:0] == 3'h1)
    |=> port_c_oe)
    else $error("verify not driven");

  verify_bits_a: assert property ((access_mode && port_e[2:0] == 3'h1 && lastValid_q
    && memBus.addr == lastAddr_q) |=> ((port_c_out & ~$past(lastData_q)) == 8'h00))
    else $error("verify shows bits not programmed");

  read_c: cover property (access_mode && port_c_oe);
  prog_c: cover property (memBus.wrEn);
  verify_c: cover property (memBus.wrEn ##[1:20] (port_c_oe && mode_supply_pin));
  refuse_c: cover property (access_mode && !mode_supply_pin && $fell(port_e[`EPA_PGM_BIT]));
  disable_c: cover property (access_mode && port_e[`EPA_CE_BIT]
    && $fell(port_e[`EPA_PGM_BIT]));
endmodule
`default_nettype wire

// >>> dv/eprom_programmer.sv
// Programmer model for the EPROM access pins
`timescale 1ns/1ns
`default_nettype none
module eprom_programmer
(
  input wire logic clk,
  output logic rstN = 1'b1,
  output logic vpp = 1'b0,
  output logic [7:0] aLo = 8'h00,
  output logic [7:0] aHi = 8'hE0,
  output logic [7:0] dOut = 8'h00,
  output logic [7:0] sel = 8'h1F,
  input wire logic [7:0] dIn,
  input wire logic dOe,
  input wire logic bsy
);
  task automatic put(input logic [12:0] a, input logic [2:0] s);
    @(negedge clk);
    aLo = a[7:0];
    aHi = {3'b111, a[12:8]};
    sel = {5'b00011, s};
  endtask
  // Read or verify; released data lines toggle
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic oe);
    put(a, 3'b001);
    dOut = ~dOut;
    @(negedge clk);
    d = dIn;
    oe = dOe;
  endtask
  // Strobe pulse after address and data are set up
  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic [2:0] s,
    input logic v, output logic b, output logic oe);
    put(a, s);
    vpp = v;
    dOut = d;
    @(negedge clk);
    sel[0] = 1'b0;
    repeat (2) @(negedge clk);
    b = bsy;
    oe = dOe;
    sel[0] = 1'b1;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// >>> dv/eprom_mode_access_port_tb_top.sv
// Self-checking bench for the EPROM access port
`timescale 1ns/1ns
`default_nettype none
module eprom_mode_access_port_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rstN, vpp, oe, mode, busy, gOe, gBusy;
  logic [7:0] aLo, aHi, dOut, sel, dIn, got;
  int errCount = 0;
  int checked = 0;
  wire logic [7:0] busLevel = oe ? dIn : dOut;
  always #5 clk = ~clk;
  eprom_mode_access_port i_eprom_mode_access_port (.clk(clk), .srst(srst), .reset_n(rstN),
    .mode_supply_pin(vpp), .port_a(aLo), .port_b(aHi), .port_c_in(busLevel),
    .port_c_out(dIn), .port_c_oe(oe), .port_e(sel), .access_mode(mode), .prog_busy(busy));
  eprom_programmer i_eprom_programmer (.clk(clk), .rstN(rstN), .vpp(vpp), .aLo(aLo),
    .aHi(aHi), .dOut(dOut), .sel(sel), .dIn(dIn), .dOe(oe), .bsy(busy));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, g);
      errCount++;
    end
  endtask
  task automatic end_of_test();
    if (errCount == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic enterMode();
    int n;
    n = 0;
    @(negedge clk);
    chk("idle", 8'h00, {6'h00, mode, oe});
    i_eprom_programmer.rstN = 1'b0;
    while (mode !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    chk("mode", 8'h01, {7'h00, mode});
  endtask
  task automatic programVerify();
    i_eprom_programmer.rd(13'h1FFF, got, gOe);
    chk("erased", 8'hFF, got);
    chk("drive", 8'h01, {7'h00, gOe});
    i_eprom_programmer.wr(13'h1A5, 8'h3C, 3'b011, 1'b1, gBusy, gOe);
    chk("busy", 8'h01, {7'h00, gBusy});
    chk("float", 8'h00, {7'h00, gOe});
    i_eprom_programmer.rd(13'h1A5, got, gOe);
    chk("verify", 8'h3C, got);
    i_eprom_programmer.rd(13'h0A5, got, gOe);
    chk("high addr", 8'hFF, got);
    i_eprom_programmer.rd(13'h1A4, got, gOe);
    chk("low addr", 8'hFF, got);
  endtask
  // No supply, chip disabled twice, output enabled
  task automatic refused();
    logic [3:0] cs [4] = '{4'b0110, 4'b1111, 4'b1010, 4'b0011};
    for (int i = 0; i < 4; i++)
    begin
      i_eprom_programmer.wr(13'h1A5, 8'h00, cs[i][3:1], cs[i][0], gBusy, gOe);
      chk("no busy", 8'h00, {7'h00, gBusy});
      if (i < 3)
        chk("no drive", 8'h00, {7'h00, gOe});
      i_eprom_programmer.rd(13'h1A5, got, gOe);
      chk("kept", 8'h3C, got);
    end
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    enterMode();
    if (mode === 1'b1)
    begin
      programVerify();
      refused();
    end
    end_of_test();
  end
endmodule
`default_nettype wire
